//--- hdl/ptsc_port_ctl.sv
/*
  Time sync port state control: mode register, port state machine,
  announce wait timer, message gate and interrupt logic.
  Assumes a protocol engine that reports announces, best-master advice,
  calibration and faults, and asks before each message moves.
*/
`default_nettype none
module ptsc_port_ctl #(
  parameter int ANNOUNCE_WAIT_CYC = ptsc_pkg::ANNOUNCE_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic init_done,
  input wire logic peer_port_init,
  input wire logic peer_port_fault,
  input wire logic fault_detect,
  input wire logic fault_confined,
  input wire logic fault_clear,
  input wire logic announce_rx,
  input wire logic [1:0] bmc_rec,
  input wire logic calib_done,
  input wire logic tx_req,
  input wire logic [3:0] tx_type,
  input wire logic tx_mgmt_resp,
  input wire logic rx_valid,
  input wire logic [3:0] rx_type,
  output logic tx_grant,
  output logic tx_deny,
  output logic rx_accept,
  output logic rx_drop,
  output logic [3:0] time_sync_port_state,
  output logic all_ports_init,
  output logic all_ports_fault,
  output logic servo_init,
  output logic servo_run,
  output logic time_source
);
  ptsc_pkg::ptsc_state_t st;
  ptsc_pkg::ptsc_state_t next_st;
  logic [1:0] time_sync_mode_select;
  logic [31:0] wait_cnt;
  logic wait_run;
  logic announce_wait_expiry;
  logic [7:0] q_cnt;
  logic q_done;
  logic seen_remote;
  logic is_auto;
  logic is_off;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_ev;
  logic rd_status;

  ptsc_gate_if gi ();

  assign is_auto = (time_sync_mode_select == ptsc_pkg::MODE_AUTO);
  assign is_off = (time_sync_mode_select == ptsc_pkg::MODE_OFF);
  assign rd_status = rd && (addr == ptsc_pkg::REG_IRQ_STATUS);

  // ****************************************
  // Message gate.
  // ****************************************
  assign gi.st = st;
  assign gi.mode_off = is_off;
  assign gi.tx_req = tx_req;
  assign gi.tx_type = tx_type;
  assign gi.tx_mgmt_resp = tx_mgmt_resp;
  assign gi.rx_valid = rx_valid;
  assign gi.rx_type = rx_type;

  ptsc_msg_gate u_gate (
    .clk(clk),
    .rst(rst),
    .g(gi.gate)
  );

  assign tx_grant = gi.tx_grant;
  assign tx_deny = gi.tx_deny;
  assign rx_accept = gi.rx_accept;
  assign rx_drop = gi.rx_drop;
  assign time_sync_port_state = st;

  // ****************************************
  // Announce wait timer.
  // ****************************************
  always_comb
  begin
    case (st)
      ptsc_pkg::PS_LISTENING,
      ptsc_pkg::PS_PASSIVE,
      ptsc_pkg::PS_UNCAL,
      ptsc_pkg::PS_SLAVE: wait_run = 1'b1;
      default: wait_run = 1'b0;
    endcase
  end

  assign announce_wait_expiry = wait_run && !announce_rx
    && (wait_cnt == 32'(ANNOUNCE_WAIT_CYC - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 32'h0;
    end
    else if (!wait_run || announce_rx || announce_wait_expiry || (next_st != st))
    begin
      wait_cnt <= 32'h0;
    end
    else
    begin
      wait_cnt <= wait_cnt + 32'h1;
    end
  end

  // ****************************************
  // Tentative leader qualification.
  // ****************************************
  assign q_done = (st == ptsc_pkg::PS_TENTATIVE) && (q_cnt == ptsc_pkg::QUALIFY_CYC - 8'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_cnt <= 8'h0;
    end
    else if ((st != ptsc_pkg::PS_TENTATIVE) || (next_st != st))
    begin
      q_cnt <= 8'h0;
    end
    else
    begin
      q_cnt <= q_cnt + 8'h1;
    end
  end

  // ****************************************
  // Remote master seen.
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seen_remote <= 1'b0;
    end
    else if (!is_auto)
    begin
      seen_remote <= 1'b0;
    end
    else if ((st == ptsc_pkg::PS_UNCAL) || (st == ptsc_pkg::PS_SLAVE))
    begin
      seen_remote <= 1'b1;
    end
  end

  // ****************************************
  // Port state machine.
  // ****************************************
  always_comb
  begin
    next_st = st;
    case (st)
      ptsc_pkg::PS_INIT:
      begin
        if (init_done)
        begin
          next_st = is_off ? ptsc_pkg::PS_DISABLED : ptsc_pkg::PS_LISTENING;
        end
      end
      ptsc_pkg::PS_FAULTY:
      begin
        if (fault_clear)
        begin
          next_st = ptsc_pkg::PS_INIT;
        end
      end
      ptsc_pkg::PS_DISABLED:
      begin
        if (!is_off)
        begin
          next_st = ptsc_pkg::PS_LISTENING;
        end
      end
      ptsc_pkg::PS_LISTENING,
      ptsc_pkg::PS_PASSIVE,
      ptsc_pkg::PS_UNCAL,
      ptsc_pkg::PS_SLAVE,
      ptsc_pkg::PS_TENTATIVE,
      ptsc_pkg::PS_MASTER,
      ptsc_pkg::PS_BEST:
      begin
        if (announce_rx && (bmc_rec == ptsc_pkg::REC_SLAVE))
        begin
          if (st != ptsc_pkg::PS_SLAVE)
          begin
            next_st = ptsc_pkg::PS_UNCAL;
          end
        end
        else if (announce_rx && (bmc_rec == ptsc_pkg::REC_PASSIVE))
        begin
          next_st = ptsc_pkg::PS_PASSIVE;
        end
        else if (announce_rx && (bmc_rec == ptsc_pkg::REC_MASTER) && is_auto
          && (st != ptsc_pkg::PS_MASTER) && (st != ptsc_pkg::PS_BEST))
        begin
          next_st = ptsc_pkg::PS_TENTATIVE;
        end
        else if (announce_wait_expiry)
        begin
          next_st = is_auto ? ptsc_pkg::PS_TENTATIVE : ptsc_pkg::PS_LISTENING;
        end
        else if ((st == ptsc_pkg::PS_UNCAL) && calib_done)
        begin
          next_st = ptsc_pkg::PS_SLAVE;
        end
        else if (q_done)
        begin
          next_st = seen_remote ? ptsc_pkg::PS_BEST : ptsc_pkg::PS_MASTER;
        end
        if (!is_auto && ((st == ptsc_pkg::PS_TENTATIVE) || (st == ptsc_pkg::PS_MASTER)
          || (st == ptsc_pkg::PS_BEST)))
        begin
          next_st = ptsc_pkg::PS_LISTENING;
        end
      end
      default: next_st = ptsc_pkg::PS_INIT;
    endcase
    if (st != ptsc_pkg::PS_INIT && st != ptsc_pkg::PS_FAULTY)
    begin
      if (is_off)
      begin
        next_st = ptsc_pkg::PS_DISABLED;
      end
      else if (fault_detect || peer_port_fault)
      begin
        next_st = ptsc_pkg::PS_FAULTY;
      end
    end
    if (peer_port_init && st != ptsc_pkg::PS_FAULTY)
    begin
      next_st = ptsc_pkg::PS_INIT;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= ptsc_pkg::PS_INIT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Status outputs toward the system.
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      all_ports_init <= 1'b1;
      servo_init <= 1'b0;
      servo_run <= 1'b0;
      time_source <= 1'b0;
    end
    else
    begin
      all_ports_init <= (next_st == ptsc_pkg::PS_INIT);
      servo_init <= (next_st == ptsc_pkg::PS_UNCAL);
      servo_run <= (next_st == ptsc_pkg::PS_SLAVE);
      time_source <= (next_st == ptsc_pkg::PS_MASTER)
        || (next_st == ptsc_pkg::PS_BEST);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      all_ports_fault <= 1'b0;
    end
    else if (fault_detect && !fault_confined && !is_off)
    begin
      all_ports_fault <= 1'b1;
    end
    else if (fault_clear)
    begin
      all_ports_fault <= 1'b0;
    end
  end

  // ****************************************
  // Mode register.
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      time_sync_mode_select <= ptsc_pkg::MODE_RESET;
    end
    else if (wr && (addr == ptsc_pkg::REG_MODE) && (wdata[1:0] != 2'h3))
    begin
      time_sync_mode_select <= wdata[1:0];
    end
  end

  // ****************************************
  // Interrupts.
  // ****************************************
  always_comb
  begin
    irq_ev = 3'h0;
    irq_ev[ptsc_pkg::IRQ_STATE_CHG] = (next_st != st);
    irq_ev[ptsc_pkg::IRQ_FAULT] = (next_st == ptsc_pkg::PS_FAULTY)
      && (st != ptsc_pkg::PS_FAULTY);
    irq_ev[ptsc_pkg::IRQ_EXPIRY] = announce_wait_expiry;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status <= 3'h0;
    end
    else
    begin
      irq_status <= (rd_status ? 3'h0 : irq_status) | irq_ev;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_mask <= ptsc_pkg::MASK_RESET;
    end
    else if (wr && (addr == ptsc_pkg::REG_IRQ_MASK))
    begin
      irq_mask <= wdata[2:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(((rd_status ? 3'h0 : irq_status) | irq_ev) & irq_mask);
    end
  end

  // ****************************************
  // Register read port.
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 32'h0;
    end
    else if (rd)
    begin
      case (addr)
        ptsc_pkg::REG_MODE: rdata <= {30'h0, time_sync_mode_select};
        ptsc_pkg::REG_STATE: rdata <= {28'h0, st};
        ptsc_pkg::REG_IRQ_STATUS: rdata <= {29'h0, irq_status};
        ptsc_pkg::REG_IRQ_MASK: rdata <= {29'h0, irq_mask};
        default: rdata <= 32'h0;
      endcase
    end
    else
    begin
      rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

//--- hdl/ptsc_pkg.sv
/*
  Constants, types and helpers for the time sync port state control.
  Assumes a 20 MHz clock and a plain register port with 8-bit addresses.
*/
// Behaviour
// - Mode off stops all protocol activity on the port.
// - Automatic mode enables the protocol; best-master choice picks master or slave.
// - Slave mode never offers this port as master.
// - A read-only register shows the live port state.
// - Initializing sets up the port and transmits nothing.
// - Any boundary port initializing holds every port initializing; a faulty port here stays faulty instead.
// - Faulty sends only management answers to management messages.
// - Port faults stay local; an unconfined fault makes all ports faulty.
// - Disabled sends nothing and drops all received non-management messages.
// - Listening waits for expiry or announce; sends peer delay, signaling, management answers.
// - Tentative leader acts as master but sends only peer delay, signaling, management.
// - Passive sends only peer delay, signaling and management answers.
// - A selected master leads through uncalibrated before slave.
// - The slave state actively synchronises to the selected master.
// - Best clock shown only in automatic mode after a remote master was seen.
`default_nettype none
package ptsc_pkg;
  // ****************************************
  // Register map.
  // ****************************************
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int IRQ_W = 3;
  localparam int IRQ_STATE_CHG = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_EXPIRY = 2;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int ANNOUNCE_WAIT_MS = 3000;
  localparam int ANNOUNCE_WAIT_CYC = ANNOUNCE_WAIT_MS * (CLK_HZ / 1000);
  localparam int QUALIFY_NS = 1000;
  localparam logic [7:0] QUALIFY_CYC = 8'((QUALIFY_NS * (CLK_HZ / 1_000_000)) / 1000);
  // ****************************************
  // Port states, best-master advice, message kinds.
  // ****************************************
  typedef enum logic [3:0] {
    PS_INIT,
    PS_FAULTY,
    PS_DISABLED,
    PS_LISTENING,
    PS_TENTATIVE,
    PS_MASTER,
    PS_PASSIVE,
    PS_UNCAL,
    PS_SLAVE,
    PS_BEST
  } ptsc_state_t;
  localparam logic [1:0] REC_NONE = 2'h0;
  localparam logic [1:0] REC_MASTER = 2'h1;
  localparam logic [1:0] REC_SLAVE = 2'h2;
  localparam logic [1:0] REC_PASSIVE = 2'h3;
  localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;
  localparam logic [3:0] MSG_PDELAY_FU = 4'ha;
  localparam logic [3:0] MSG_SIGNALING = 4'hc;
  localparam logic [3:0] MSG_MGMT = 4'hd;

  // True for peer delay and signaling messages.
  function automatic logic peer_or_sig(input logic [3:0] t);
    peer_or_sig = (t == MSG_PDELAY_REQ) || (t == MSG_PDELAY_RESP)
      || (t == MSG_PDELAY_FU) || (t == MSG_SIGNALING);
  endfunction
endpackage
`default_nettype wire

//--- hdl/ptsc_gate_if.sv
/*
  Carrier between the port state control and its message gate.
  Assumes both ends share one clock.
*/
`default_nettype none
interface ptsc_gate_if;
  ptsc_pkg::ptsc_state_t st;
  logic mode_off;
  logic tx_req;
  logic [3:0] tx_type;
  logic tx_mgmt_resp;
  logic rx_valid;
  logic [3:0] rx_type;
  logic tx_grant;
  logic tx_deny;
  logic rx_accept;
  logic rx_drop;
  modport ctl (output st, mode_off, tx_req, tx_type, tx_mgmt_resp, rx_valid, rx_type,
    input tx_grant, tx_deny, rx_accept, rx_drop);
  modport gate (input st, mode_off, tx_req, tx_type, tx_mgmt_resp, rx_valid, rx_type,
    output tx_grant, tx_deny, rx_accept, rx_drop);
endinterface
`default_nettype wire

//--- hdl/ptsc_msg_gate.sv
/*
  Message gate: grants or refuses each transmit and receive by port state.
  Assumes requests are one-cycle pulses synchronous to clk.
*/
`default_nettype none
module ptsc_msg_gate (
  input wire logic clk,
  input wire logic rst,
  ptsc_gate_if.gate g
);
  // ****************************************
  // Transmit and receive policy.
  // ****************************************
  function automatic logic tx_ok(input ptsc_pkg::ptsc_state_t s, input logic [3:0] t,
    input logic resp);
    case (s)
      ptsc_pkg::PS_INIT: tx_ok = 1'b0;
      ptsc_pkg::PS_DISABLED: tx_ok = 1'b0;
      ptsc_pkg::PS_FAULTY: tx_ok = (t == ptsc_pkg::MSG_MGMT) && resp;
      ptsc_pkg::PS_LISTENING,
      ptsc_pkg::PS_PASSIVE: tx_ok = ptsc_pkg::peer_or_sig(t)
        || ((t == ptsc_pkg::MSG_MGMT) && resp);
      ptsc_pkg::PS_TENTATIVE: tx_ok = ptsc_pkg::peer_or_sig(t)
        || (t == ptsc_pkg::MSG_MGMT);
      default: tx_ok = 1'b1;
    endcase
  endfunction

  function automatic logic rx_ok(input ptsc_pkg::ptsc_state_t s, input logic [3:0] t);
    case (s)
      ptsc_pkg::PS_INIT: rx_ok = 1'b0;
      ptsc_pkg::PS_DISABLED: rx_ok = (t == ptsc_pkg::MSG_MGMT);
      default: rx_ok = 1'b1;
    endcase
  endfunction

  // ****************************************
  // Registered verdicts.
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      g.tx_grant <= 1'b0;
      g.tx_deny <= 1'b0;
    end
    else
    begin
      g.tx_grant <= g.tx_req && !g.mode_off && tx_ok(g.st, g.tx_type, g.tx_mgmt_resp);
      g.tx_deny <= g.tx_req && (g.mode_off || !tx_ok(g.st, g.tx_type, g.tx_mgmt_resp));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      g.rx_accept <= 1'b0;
      g.rx_drop <= 1'b0;
    end
    else
    begin
      g.rx_accept <= g.rx_valid && !g.mode_off && rx_ok(g.st, g.rx_type);
      g.rx_drop <= g.rx_valid && (g.mode_off || !rx_ok(g.st, g.rx_type));
    end
  end
endmodule
`default_nettype wire

//--- bench/ptsc_port_ctl_props.sv
/*
  Concurrent checks on the time sync port state control, bound to its top module.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none
module ptsc_port_ctl_props #(
  parameter int ANNOUNCE_WAIT_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic peer_port_init,
  input wire logic fault_detect,
  input wire logic fault_confined,
  input wire logic tx_req,
  input wire logic [3:0] tx_type,
  input wire logic tx_mgmt_resp,
  input wire logic rx_valid,
  input wire logic [3:0] rx_type,
  input wire logic tx_grant,
  input wire logic tx_deny,
  input wire logic rx_drop,
  input wire logic [3:0] time_sync_port_state,
  input wire logic all_ports_fault,
  input wire logic servo_init,
  input wire logic servo_run,
  input wire logic time_source
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Properties.
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [3:0] st = time_sync_port_state;
  a_init_silent: assert property (st == 4'h0 && tx_req |=> tx_deny && !tx_grant)
    else $error("transmit granted while initializing");
  a_faulty_tx: assert property (st == 4'h1 && tx_req && !(tx_type == 4'hd && tx_mgmt_resp)
    |=> tx_deny) else $error("faulty port granted a transmit");
  a_disabled_rx: assert property (st == 4'h2 && rx_valid && rx_type != 4'hd |=> rx_drop)
    else $error("disabled port accepted a message");
  a_listen_tx: assert property ((st == 4'h3 || st == 4'h6) && tx_req
    && !(tx_type inside {4'h2, 4'h3, 4'ha, 4'hc}) && !(tx_type == 4'hd && tx_mgmt_resp)
    |=> tx_deny) else $error("listening or passive port granted a transmit");
  a_tent_tx: assert property (st == 4'h4 && tx_req
    && tx_type inside {4'h2, 4'h3, 4'ha, 4'hc, 4'hd} |=> tx_grant)
    else $error("tentative leader refused an allowed transmit");
  a_master_tx: assert property (st == 4'h5 && tx_req |=> tx_grant)
    else $error("master refused a transmit");
  a_peer_init: assert property (peer_port_init && st != 4'h1 |=> st == 4'h0)
    else $error("peer initializing did not hold this port");
  a_uncal_first: assert property (st == 4'h8 && $past(st) != 4'h8 |-> $past(st) == 4'h7)
    else $error("slave entered without uncalibrated");
  a_best_from: assert property (st == 4'h9 && $past(st) != 4'h9 |-> $past(st) == 4'h4)
    else $error("best clock entered from wrong state");
  a_status_flags: assert property (servo_init == (st == 4'h7) && servo_run == (st == 4'h8)
    && time_source == (st == 4'h5 || st == 4'h9)) else $error("status flags disagree");
  a_unconf_fault: assert property (fault_detect && !fault_confined && st > 4'h2
    && !peer_port_init |=> all_ports_fault) else $error("unconfined fault not spread");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind ptsc_port_ctl ptsc_port_ctl_props #(.ANNOUNCE_WAIT_CYC(ANNOUNCE_WAIT_CYC)) u_props (
  .clk, .rst, .rd, .rdata, .peer_port_init, .fault_detect, .fault_confined, .tx_req,
  .tx_type, .tx_mgmt_resp, .rx_valid, .rx_type, .tx_grant, .tx_deny, .rx_drop,
  .time_sync_port_state, .all_ports_fault, .servo_init, .servo_run, .time_source);
`default_nettype wire

//--- bench/ptsc_far_clock.sv
/*
  Model of the remote time sync clocks on the network.
  Assumes its tasks are called between clock edges.
*/
`default_nettype none
module ptsc_far_clock (
  input wire logic clk,
  output logic announce_rx,
  output logic [1:0] bmc_rec,
  output logic rx_valid,
  output logic [3:0] rx_type
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Announce and message source.
  // ****************************************
  logic ann_go = 1'b0;
  logic msg_go = 1'b0;
  logic [1:0] ann_rec = 2'h0;
  logic [3:0] msg_t = 4'h0;
  initial
  begin
    announce_rx = 1'b0;
    bmc_rec = 2'h0;
    rx_valid = 1'b0;
    rx_type = 4'h0;
  end
  // Idle advice and type change every cycle so stale values are never trusted.
  always @(posedge clk)
  begin
    announce_rx <= ann_go;
    bmc_rec <= ann_go ? ann_rec : ~bmc_rec;
    rx_valid <= msg_go;
    rx_type <= msg_go ? msg_t : rx_type + 4'h1;
    ann_go <= 1'b0;
    msg_go <= 1'b0;
  end
  task automatic announce(input logic [1:0] rec);
    ann_rec = rec;
    ann_go = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic msg(input logic [3:0] t);
    msg_t = t;
    msg_go = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
  Self-checking bench for the time sync port state control.
  Assumes the far clock model and a shortened announce wait.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bench.
  // ****************************************
  localparam int WAIT_CYC = 50;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, init_done = 1'b0;
  logic peer_port_init = 1'b0, peer_port_fault = 1'b0, fault_detect = 1'b0;
  logic fault_confined = 1'b1, fault_clear = 1'b0, calib_done = 1'b0;
  logic tx_req = 1'b0, tx_mgmt_resp = 1'b0;
  logic [3:0] tx_type = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic irq, tx_grant, tx_deny, rx_accept, rx_drop, all_ports_init, all_ports_fault;
  logic servo_init, servo_run, time_source, announce_rx, rx_valid;
  logic [1:0] bmc_rec;
  logic [3:0] rx_type, time_sync_port_state;
  int mismatches = 0, samples_checked = 0;
  always #25 clk = ~clk;
  ptsc_port_ctl #(.ANNOUNCE_WAIT_CYC(WAIT_CYC)) uut (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .irq, .init_done, .peer_port_init, .peer_port_fault, .fault_detect,
    .fault_confined, .fault_clear, .announce_rx, .bmc_rec, .calib_done, .tx_req, .tx_type,
    .tx_mgmt_resp, .rx_valid, .rx_type, .tx_grant, .tx_deny, .rx_accept, .rx_drop,
    .time_sync_port_state, .all_ports_init, .all_ports_fault, .servo_init, .servo_run,
    .time_source);
  ptsc_far_clock far (.clk, .announce_rx, .bmc_rec, .rx_valid, .rx_type);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cst(input logic [3:0] exp);
    chk({28'h0, time_sync_port_state}, {28'h0, exp});
  endtask
  task automatic wait_st(input logic [3:0] exp, input int n);
    for (int i = 0; i < n && time_sync_port_state !== exp; i++)
    begin
      @(posedge clk);
      #1;
    end
    cst(exp);
    if (time_sync_port_state !== exp)
      end_sim();
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask
  task automatic tx(input logic [3:0] t, input logic r, input logic g);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_type <= t;
    tx_mgmt_resp <= r;
    @(posedge clk);
    tx_req <= 1'b0;
    #1;
    chk(32'({tx_grant, tx_deny}), 32'({g, !g}));
  endtask
  task automatic rx(input logic [3:0] t, input logic a);
    far.msg(t);
    chk(32'({rx_accept, rx_drop}), 32'({a, !a}));
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: fault_clear <= 1'b1;
      1: calib_done <= 1'b1;
      default: fault_detect <= 1'b1;
    endcase
    @(posedge clk);
    fault_clear <= 1'b0;
    calib_done <= 1'b0;
    fault_detect <= 1'b0;
    #1;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    cst(4'h0);
    chk(32'(all_ports_init), 32'h1);
    tx(4'hd, 1'b1, 1'b0);
    rx(4'hd, 1'b0);
    reg_rd(ptsc_pkg::REG_MODE, 32'hffffffff, 32'h0);
    reg_rd(ptsc_pkg::REG_IRQ_MASK, 32'hffffffff, 32'h0);
    $display("test reset done");
    @(posedge clk);
    init_done <= 1'b1;
    wait_st(4'h2, 5);
    tx(4'hd, 1'b1, 1'b0);
    rx(4'hd, 1'b0);
    rx(4'h0, 1'b0);
    reg_wr(ptsc_pkg::REG_MODE, 32'h3);
    reg_rd(ptsc_pkg::REG_MODE, 32'hffffffff, 32'h0);
    reg_wr(ptsc_pkg::REG_STATE, 32'h5);
    reg_rd(ptsc_pkg::REG_STATE, 32'hffffffff, 32'h2);
    reg_rd(8'h10, 32'hffffffff, 32'h0);
    chk(32'(irq), 32'h0);
    reg_rd(ptsc_pkg::REG_IRQ_STATUS, 32'h1, 32'h1);
    reg_rd(ptsc_pkg::REG_IRQ_STATUS, 32'hffffffff, 32'h0);
    $display("test off done");
    reg_wr(ptsc_pkg::REG_IRQ_MASK, 32'h7);
    reg_wr(ptsc_pkg::REG_MODE, {30'h0, ptsc_pkg::MODE_AUTO});
    wait_st(4'h3, 5);
    chk(32'(irq), 32'h1);
    far.announce(ptsc_pkg::REC_NONE);
    for (int i = 0; i < 16; i++)
      tx(i[3:0], 1'b0, i inside {2, 3, 10, 12});
    tx(4'hd, 1'b1, 1'b1);
    rx(4'hb, 1'b1);
    far.announce(ptsc_pkg::REC_SLAVE);
    cst(4'h7);
    chk(32'(servo_init), 32'h1);
    pulse(1);
    cst(4'h8);
    chk(32'(servo_run), 32'h1);
    $display("test listen done");
    reg_wr(ptsc_pkg::REG_MODE, {30'h0, ptsc_pkg::MODE_SLAVE});
    far.announce(ptsc_pkg::REC_MASTER);
    cst(4'h8);
    wait_st(4'h3, WAIT_CYC + 10);
    reg_rd(ptsc_pkg::REG_IRQ_STATUS, 32'h4, 32'h4);
    reg_wr(ptsc_pkg::REG_MODE, {30'h0, ptsc_pkg::MODE_AUTO});
    far.announce(ptsc_pkg::REC_SLAVE);
    cst(4'h7);
    far.announce(ptsc_pkg::REC_MASTER);
    cst(4'h4);
    tx(4'h0, 1'b0, 1'b0);
    tx(4'hd, 1'b0, 1'b1);
    wait_st(4'h9, 30);
    chk(32'(time_source), 32'h1);
    $display("test best done");
    reg_wr(ptsc_pkg::REG_MODE, {30'h0, ptsc_pkg::MODE_OFF});
    wait_st(4'h2, 5);
    reg_wr(ptsc_pkg::REG_MODE, {30'h0, ptsc_pkg::MODE_AUTO});
    wait_st(4'h3, 5);
    wait_st(4'h4, WAIT_CYC + 10);
    wait_st(4'h5, 30);
    tx(4'h0, 1'b0, 1'b1);
    tx(4'hb, 1'b0, 1'b1);
    far.announce(ptsc_pkg::REC_PASSIVE);
    cst(4'h6);
    tx(4'h0, 1'b0, 1'b0);
    tx(4'hc, 1'b0, 1'b1);
    $display("test master done");
    pulse(2);
    cst(4'h1);
    chk(32'(all_ports_fault), 32'h0);
    tx(4'hd, 1'b1, 1'b1);
    tx(4'hd, 1'b0, 1'b0);
    pulse(0);
    wait_st(4'h3, 10);
    @(posedge clk);
    fault_confined <= 1'b0;
    pulse(2);
    cst(4'h1);
    chk(32'(all_ports_fault), 32'h1);
    @(posedge clk);
    fault_confined <= 1'b1;
    pulse(0);
    wait_st(4'h3, 10);
    chk(32'(all_ports_fault), 32'h0);
    @(posedge clk);
    peer_port_fault <= 1'b1;
    wait_st(4'h1, 5);
    @(posedge clk);
    peer_port_fault <= 1'b0;
    pulse(0);
    wait_st(4'h3, 10);
    @(posedge clk);
    peer_port_init <= 1'b1;
    wait_st(4'h0, 5);
    chk(32'(all_ports_init), 32'h1);
    rx(4'h0, 1'b0);
    @(posedge clk);
    peer_port_init <= 1'b0;
    wait_st(4'h3, 10);
    $display("test fault done");
    end_sim();
  end
endmodule
`default_nettype wire
